// [core/stl_option_logic.sv]
`default_nettype none
`include "stl_defines.svh"
module stl_option_logic #(
    parameter stl_pkg::stl_variant_t VARIANT = stl_pkg::STL_VAR_FULL,
    parameter int                    CNT_W   = 27
) (
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    // wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    output logic             o_irq,
    // serial partner
    input  wire logic        i_dsr,
    input  wire logic        i_cts,
    output logic             o_dtr,
    output logic             o_rts,
    // received and tape data
    input  wire logic        i_rx_valid,
    input  wire logic [7:0]  i_rx_data,
    input  wire logic        i_rx_parity_err,
    input  wire logic        i_tape_valid,
    input  wire logic [7:0]  i_tape_data,
    input  wire logic        i_reader_ready,
    input  wire logic        i_tx_req,
    // outputs to engines
    output logic             o_ready_led,
    output logic             o_tx_enable,
    output logic             o_reader_run,
    output logic             o_punch_valid,
    output logic [7:0]       o_punch_data,
    output logic             o_echo_valid,
    output logic [7:0]       o_echo_data,
    output logic             o_modem_only
);
    localparam logic [CNT_W-1:0] MS_CYC = CNT_W'(`STL_MS_CYCLES);

    initial begin
        if (CNT_W < 27) $error("stl_option_logic: CNT_W too narrow for 1 s");
    end

    // register state
    logic [9:0]  ctrl, next_ctrl;
    logic [9:0]  delay_ms, next_delay_ms;
    logic [7:0]  delay_char, next_delay_char;
    logic [7:0]  stop_char, next_stop_char;
    logic [2:0]  irq_stat, next_irq_stat;
    logic [2:0]  irq_mask, next_irq_mask;
    logic        par_lost, next_par_lost;
    stl_pkg::stl_rdr_state_t rdr, next_rdr;
    // output state
    logic        dtr, ready_led, rts, tx_en, rdr_run, irq, modem_only;
    logic        next_dtr, next_ready_led, next_rts, next_tx_en, next_rdr_run;
    logic        punch_v, echo_v, next_punch_v, next_echo_v;
    logic [7:0]  punch_d, echo_d, next_punch_d, next_echo_d;

    logic        wr_stb;
    logic [7:0]  wr_adr;
    logic [31:0] wr_dat;
    logic        pause_busy, pause_start;
    logic        delay_en, stop_en, reader_only, remote, dsr_ok, cts_ok, ev_par, ev_delay, ev_stop;
    logic [31:0] status;

    function automatic logic is_char(input logic v, input logic [7:0] d, input logic [7:0] c);
        is_char = v && (d == c);
    endfunction : is_char

    stl_wb_regs u_regs (
        .i_clk_sys  (i_clk_sys),
        .i_rst      (i_rst),
        .i_wb_cyc   (i_wb_cyc),
        .i_wb_stb   (i_wb_stb),
        .i_wb_we    (i_wb_we),
        .i_wb_adr   (i_wb_adr),
        .i_wb_sel   (i_wb_sel),
        .i_wb_dat   (i_wb_dat),
        .o_wb_dat   (o_wb_dat),
        .o_wb_ack   (o_wb_ack),
        .i_status   (status),
        .i_irq_stat (irq_stat),
        .i_ctrl     (ctrl),
        .i_irq_mask (irq_mask),
        .i_delay_ms (delay_ms),
        .i_chars    ({stop_char, delay_char}),
        .o_wr_stb   (wr_stb),
        .o_wr_adr   (wr_adr),
        .o_wr_dat   (wr_dat)
    );

    stl_pause_timer #(.CNT_W(CNT_W)) u_pause (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_start   (pause_start),
        .i_cycles  (CNT_W'(delay_ms * MS_CYC)),
        .o_busy    (pause_busy)
    );

    // option decoding
    always_comb begin
        reader_only = (VARIANT == stl_pkg::STL_VAR_READER_ONLY);
        remote      = ctrl[`STL_CTRL_REMOTE] && !reader_only;
        delay_en    = !ctrl[`STL_CTRL_DELAY_DIS] && !reader_only;
        stop_en     = ctrl[`STL_CTRL_DELAY_DIS] && remote;
        dsr_ok      = ctrl[`STL_CTRL_DSR_INTERNAL] ? 1'b1 : i_dsr;
        cts_ok      = ctrl[`STL_CTRL_CTS_EXTERNAL] ? i_cts : 1'b1;
        ev_par      = i_rx_valid && i_rx_parity_err;
        ev_delay    = delay_en && is_char(i_tape_valid, i_tape_data, delay_char) && rdr_run;
        ev_stop     = stop_en && is_char(i_tape_valid, i_tape_data, stop_char) && rdr_run;
        pause_start = ev_delay;
        status      = {25'h0, par_lost, rdr == stl_pkg::STL_STOP, pause_busy, cts_ok, dsr_ok, dtr, ready_led};
    end

    // register writes and sticky events
    always_comb begin
        next_ctrl       = ctrl;
        next_delay_ms   = delay_ms;
        next_delay_char = delay_char;
        next_stop_char  = stop_char;
        next_irq_mask   = irq_mask;
        next_irq_stat   = irq_stat;
        if (wr_stb) begin
            case (wr_adr)
                `STL_REG_CTRL:     next_ctrl = wr_dat[9:0];
                `STL_REG_IRQ_STAT: next_irq_stat = irq_stat & ~wr_dat[2:0];
                `STL_REG_IRQ_MASK: next_irq_mask = wr_dat[2:0];
                `STL_REG_DELAY: begin
                    // values beyond ten bits must not alias into range
                    if (wr_dat[31:10] == 22'h0
                        && wr_dat[9:0] >= 10'(`STL_PAUSE_MIN_MS)
                        && wr_dat[9:0] <= 10'(`STL_PAUSE_MAX_MS)) begin
                        next_delay_ms = wr_dat[9:0];
                    end
                end
                `STL_REG_CHARS: begin
                    next_delay_char = wr_dat[7:0];
                    next_stop_char  = wr_dat[15:8];
                end
                default: ;
            endcase
        end
        if (reader_only) begin
            next_ctrl[`STL_CTRL_CURRENT_LOOP] = 1'b0;
            next_ctrl[`STL_CTRL_ECHO]         = 1'b0;
        end
        // set wins over clear
        next_irq_stat = next_irq_stat | {ev_stop, ev_delay, ev_par};
    end

    // reader state machine
    always_comb begin
        next_rdr = rdr;
        case (rdr)
            stl_pkg::STL_RUN: begin
                if (ev_stop) next_rdr = stl_pkg::STL_STOP;
                else if (ev_delay) next_rdr = stl_pkg::STL_PAUSE;
            end
            stl_pkg::STL_PAUSE: begin
                if (!pause_start && !pause_busy) next_rdr = stl_pkg::STL_RUN;
            end
            stl_pkg::STL_STOP: begin
                if (!ctrl[`STL_CTRL_READER_ON]) next_rdr = stl_pkg::STL_RUN;
            end
            default: next_rdr = stl_pkg::STL_RUN;
        endcase
    end

    // ready, handshake, echo and punch paths
    always_comb begin
        logic rdr_ok;
        rdr_ok         = ctrl[`STL_CTRL_RDR_PRESENT] ? i_reader_ready : 1'b1;
        next_par_lost  = par_lost | (ctrl[`STL_CTRL_PAR_DROPS] && ev_par);
        next_ready_led = rdr_ok && dsr_ok && !next_par_lost;
        next_dtr       = next_ready_led;
        next_rts       = ctrl[`STL_CTRL_CTS_EXTERNAL] && i_tx_req;
        next_tx_en     = cts_ok;
        next_rdr_run   = ctrl[`STL_CTRL_READER_ON] && !ctrl[`STL_CTRL_ECHO]
                         && next_rdr == stl_pkg::STL_RUN && rdr_ok;
        next_punch_v   = i_rx_valid && !reader_only && (ctrl[`STL_CTRL_ECHO] || ctrl[`STL_CTRL_PUNCH_ON]
                         || remote);
        next_punch_d   = i_rx_data;
        next_echo_v    = i_rx_valid && ctrl[`STL_CTRL_ECHO];
        next_echo_d    = i_rx_data;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ctrl       <= `STL_CTRL_RESET;
            delay_ms   <= 10'(`STL_PAUSE_DEF_MS);
            delay_char <= `STL_CHAR_DELAY_RST;
            stop_char  <= `STL_CHAR_STOP_RST;
            irq_stat   <= 3'h0;
            irq_mask   <= 3'h0;
            par_lost   <= 1'b0;
            rdr        <= stl_pkg::STL_RUN;
            dtr        <= 1'b0;
            ready_led  <= 1'b0;
            rts        <= 1'b0;
            tx_en      <= 1'b0;
            rdr_run    <= 1'b0;
            punch_v    <= 1'b0;
            punch_d    <= 8'h00;
            echo_v     <= 1'b0;
            echo_d     <= 8'h00;
            irq        <= 1'b0;
            modem_only <= 1'b0;
        end else begin
            ctrl       <= next_ctrl;
            delay_ms   <= next_delay_ms;
            delay_char <= next_delay_char;
            stop_char  <= next_stop_char;
            irq_stat   <= next_irq_stat;
            irq_mask   <= next_irq_mask;
            par_lost   <= next_par_lost;
            rdr        <= next_rdr;
            dtr        <= next_dtr;
            ready_led  <= next_ready_led;
            rts        <= next_rts;
            tx_en      <= next_tx_en;
            rdr_run    <= next_rdr_run;
            punch_v    <= next_punch_v;
            punch_d    <= next_punch_d;
            echo_v     <= next_echo_v;
            echo_d     <= next_echo_d;
            irq        <= |(next_irq_stat & next_irq_mask);
            modem_only <= (VARIANT != stl_pkg::STL_VAR_FULL);
        end
    end

    assign o_dtr         = dtr;
    assign o_ready_led   = ready_led;
    assign o_rts         = rts;
    assign o_tx_enable   = tx_en;
    assign o_reader_run  = rdr_run;
    assign o_punch_valid = punch_v;
    assign o_punch_data  = punch_d;
    assign o_echo_valid  = echo_v;
    assign o_echo_data   = echo_d;
    assign o_irq         = irq;
    assign o_modem_only  = modem_only;

    // checks
    a_par_sticky: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        par_lost |=> !o_dtr && !o_ready_led) else $error("ready after parity drop");
    a_par_drop: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        ctrl[`STL_CTRL_PAR_DROPS] && ev_par |=> !o_dtr) else $error("dtr not dropped");
    a_cts_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        ctrl[`STL_CTRL_CTS_EXTERNAL] && !i_cts |=> !o_tx_enable) else $error("tx without cts");
    a_cts_int: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !i_rst && !ctrl[`STL_CTRL_CTS_EXTERNAL] |=> o_tx_enable) else $error("internal cts low");
    a_rts_int: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !ctrl[`STL_CTRL_CTS_EXTERNAL] |=> !o_rts) else $error("rts with internal cts");
    a_echo_idle: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        ctrl[`STL_CTRL_ECHO] |=> !o_reader_run) else $error("reader runs in echo");
    a_echo_copy: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_rx_valid && ctrl[`STL_CTRL_ECHO] |=> o_echo_valid && o_punch_valid && o_echo_data == $past(i_rx_data))
        else $error("echo lost");
    a_punch_copy: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_rx_valid && ctrl[`STL_CTRL_PUNCH_ON] && !reader_only |=> o_punch_valid && o_punch_data == $past(i_rx_data))
        else $error("punch lost");
    a_delay_pause: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        ev_delay |=> rdr == stl_pkg::STL_PAUSE ##1 !o_reader_run) else $error("no pause");
    a_stop_hit: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        ev_stop |=> rdr == stl_pkg::STL_STOP && !o_reader_run) else $error("no stop");
    a_no_stop_local: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        is_char(i_tape_valid, i_tape_data, stop_char) && rdr_run && (!remote || !ctrl[`STL_CTRL_DELAY_DIS])
        |=> rdr != stl_pkg::STL_STOP) else $error("stop outside remote");
    a_rdr_absent: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !i_rst && !ctrl[`STL_CTRL_RDR_PRESENT] && ctrl[`STL_CTRL_DSR_INTERNAL] && !next_par_lost |=> o_ready_led)
        else $error("absent reader not ready");

    // cover points
    c_pause: cover property (@(posedge i_clk_sys) ev_delay);
    c_stop: cover property (@(posedge i_clk_sys) ev_stop);
    c_par: cover property (@(posedge i_clk_sys) par_lost);
    c_echo: cover property (@(posedge i_clk_sys) o_echo_valid);
    c_irq: cover property (@(posedge i_clk_sys) o_irq);
endmodule : stl_option_logic
`default_nettype wire

// [inc/stl_defines.svh]
`ifndef STL_DEFINES_SVH
`define STL_DEFINES_SVH

// wishbone register byte offsets
`define STL_REG_CTRL      8'h00
`define STL_REG_STATUS    8'h04
`define STL_REG_IRQ_STAT  8'h08
`define STL_REG_IRQ_MASK  8'h0C
`define STL_REG_DELAY     8'h10
`define STL_REG_CHARS     8'h14

// control register fields
`define STL_CTRL_RDR_PRESENT  0
`define STL_CTRL_DSR_INTERNAL 1
`define STL_CTRL_CTS_EXTERNAL 2
`define STL_CTRL_PAR_DROPS    3
`define STL_CTRL_DELAY_DIS    4
`define STL_CTRL_CURRENT_LOOP 5
`define STL_CTRL_ECHO         6
`define STL_CTRL_REMOTE       7
`define STL_CTRL_READER_ON    8
`define STL_CTRL_PUNCH_ON     9
`define STL_CTRL_RESET        10'h002

// status register fields
`define STL_ST_READY   0
`define STL_ST_DTR     1
`define STL_ST_DSR     2
`define STL_ST_CTS     3
`define STL_ST_PAUSE   4
`define STL_ST_STOPPED 5
`define STL_ST_PARLOST 6

// interrupt event bits
`define STL_IRQ_PARITY 0
`define STL_IRQ_DELAY  1
`define STL_IRQ_STOP   2
`define STL_IRQ_W      3

// character defaults
`define STL_CHAR_DELAY_RST 8'h0D
`define STL_CHAR_STOP_RST  8'h13

// pause timing
`define STL_CLK_HZ       100000000
`define STL_PAUSE_MIN_MS 10
`define STL_PAUSE_MAX_MS 1000
`define STL_PAUSE_DEF_MS 600
`define STL_MS_CYCLES    (`STL_CLK_HZ / 1000)

`endif

// [inc/stl_pkg.sv]
`default_nettype none
package stl_pkg;
    typedef enum logic [1:0] {
        STL_RUN   = 2'b00,
        STL_PAUSE = 2'b01,
        STL_STOP  = 2'b11
    } stl_rdr_state_t;

    typedef enum logic [1:0] {
        STL_VAR_FULL        = 2'b00,
        STL_VAR_SINGLE_PORT = 2'b01,
        STL_VAR_READER_ONLY = 2'b10
    } stl_variant_t;
endpackage : stl_pkg
`default_nettype wire

// [core/stl_pause_timer.sv]
`default_nettype none
`include "stl_defines.svh"
module stl_pause_timer #(
    parameter int CNT_W = 27
) (
    // clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst,
    // control
    input  wire logic             i_start,
    input  wire logic [CNT_W-1:0] i_cycles,
    // state
    output logic                  o_busy
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;

    initial begin
        if (CNT_W < 2 || CNT_W > 32) $error("stl_pause_timer: CNT_W out of range");
    end

    // restart on every start pulse
    always_comb begin
        next_count = count;
        if (i_start) begin
            next_count = i_cycles;
        end else if (count != '0) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign o_busy = (count != '0);
endmodule : stl_pause_timer
`default_nettype wire

// [core/stl_wb_regs.sv]
`default_nettype none
`include "stl_defines.svh"
module stl_wb_regs (
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    // wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    // register contents
    input  wire logic [31:0] i_status,
    input  wire logic [2:0]  i_irq_stat,
    input  wire logic [9:0]  i_ctrl,
    input  wire logic [2:0]  i_irq_mask,
    input  wire logic [9:0]  i_delay_ms,
    input  wire logic [15:0] i_chars,
    output logic             o_wr_stb,
    output logic [7:0]       o_wr_adr,
    output logic [31:0]      o_wr_dat
);
    logic        ack;
    logic        next_ack;
    logic [31:0] rdat;
    logic [31:0] next_rdat;

    // one request answered one cycle after it is seen; ack drops next cycle
    always_comb begin
        next_ack  = i_wb_cyc && i_wb_stb && !ack;
        next_rdat = rdat;
        if (next_ack && !i_wb_we) begin
            case (i_wb_adr)
                `STL_REG_CTRL:     next_rdat = {22'h0, i_ctrl};
                `STL_REG_STATUS:   next_rdat = i_status;
                `STL_REG_IRQ_MASK: next_rdat = {29'h0, i_irq_mask};
                `STL_REG_DELAY:    next_rdat = {22'h0, i_delay_ms};
                `STL_REG_CHARS:    next_rdat = {16'h0, i_chars};
                `STL_REG_IRQ_STAT: next_rdat = {29'h0, i_irq_stat};
                default:           next_rdat = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ack  <= 1'b0;
            rdat <= 32'h0;
        end else begin
            ack  <= next_ack;
            rdat <= next_rdat;
        end
    end

    assign o_wb_ack = ack;
    assign o_wb_dat = rdat;
    assign o_wr_stb = i_wb_cyc && i_wb_stb && i_wb_we && ack;
    assign o_wr_adr = i_wb_adr;
    assign o_wr_dat = i_wb_dat & {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
endmodule : stl_wb_regs
`default_nettype wire

// [verif/stl_modem_model.sv]
`default_nettype none
module stl_modem_model (
    // clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    // bench settings
    input  wire logic       i_ready,
    input  wire logic [3:0] i_lat,
    // modem side lines
    input  wire logic       i_rts,
    output logic            o_dsr,
    output logic            o_cts
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] cnt;

    // ready level of the modem
    assign o_dsr = i_ready;

    // clear to send answers request to send after i_lat + 1 cycles
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || !i_rts) begin
            cnt   <= 4'h0;
            o_cts <= 1'b0;
        end else if (cnt >= i_lat) begin
            o_cts <= 1'b1;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule : stl_modem_model
`default_nettype wire

// [verif/serial_tape_link_options_test.sv]
`default_nettype none
module serial_tape_link_options_test;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {logic [31:0] v; logic [31:0] m;} stl_rd_t;

    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00, rxd = 8'h00, tpd = 8'h00, pd, ed;
    logic [3:0]  sel = 4'hF, lat = 4'h3;
    logic [31:0] wdat = 32'h0, rdat;
    logic        ack, irq, dsr, cts, dtr, rts, rdy, txen, run, pv, ev, mo;
    logic        rxv = 1'b0, pe = 1'b0, tpv = 1'b0, rrdy = 1'b0, txr = 1'b0, pready = 1'b0;
    int          n_errors = 0, check_count = 0;
    stl_rd_t     rq[$], re;
    logic [7:0]  pq[$], eq[$];
    logic [31:0] dw[4] = '{32'h009, 32'h3E9, 32'h3E8, 32'h00A};
    logic [31:0] dx[4] = '{32'h258, 32'h258, 32'h3E8, 32'h00A};

    always #5 clk = ~clk;

    stl_option_logic stl_option_logic_i (
        .i_clk_sys(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_irq(irq), .i_dsr(dsr),
        .i_cts(cts), .o_dtr(dtr), .o_rts(rts), .i_rx_valid(rxv), .i_rx_data(rxd), .i_rx_parity_err(pe),
        .i_tape_valid(tpv), .i_tape_data(tpd), .i_reader_ready(rrdy), .i_tx_req(txr), .o_ready_led(rdy),
        .o_tx_enable(txen), .o_reader_run(run), .o_punch_valid(pv), .o_punch_data(pd),
        .o_echo_valid(ev), .o_echo_data(ed), .o_modem_only(mo));

    stl_modem_model stl_modem_model_i (
        .i_clk_sys(clk), .i_rst(rst), .i_ready(pready), .i_lat(lat), .i_rts(rts), .o_dsr(dsr), .o_cts(cts));

    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %0h seen %0h", n, e, g);
        end
    endtask : cmp

    task automatic lv(input string n, input logic e, input logic g);
        cmp(n, {31'h0, e}, {31'h0, g});
    endtask : lv

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n == 50) lv("wb_ack", 1'b1, 1'b0);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
        rq.push_back('{v & m, m});
        wb(1'b0, a, 32'h0);
    endtask : rd

    task automatic rx(input logic [7:0] d, input logic err, input logic p, input logic e);
        if (p) pq.push_back(d);
        if (e) eq.push_back(d);
        rxv <= 1'b1;
        rxd <= d;
        pe  <= err;
        @(posedge clk);
        rxv <= 1'b0;
        pe  <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : rx

    task automatic tape(input logic [7:0] d);
        tpv <= 1'b1;
        tpd <= d;
        @(posedge clk);
        tpv <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : tape

    task automatic do_reset;
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask : do_reset

    task automatic summarize;
        if (rq.size() + pq.size() + eq.size() != 0) lv("pending", 1'b0, 1'b1);
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    // result watcher: read data, punch and echo pulses
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (rq.size() == 0) lv("rd_extra", 1'b0, 1'b1);
            else begin
                re = rq.pop_front();
                cmp("rdata", re.v, rdat & re.m);
            end
        end
        if (pv === 1'b1) begin
            if (pq.size() == 0) lv("punch_extra", 1'b0, 1'b1);
            else cmp("punch", {24'h0, pq.pop_front()}, {24'h0, pd});
        end
        if (ev === 1'b1) begin
            if (eq.size() == 0) lv("echo_extra", 1'b0, 1'b1);
            else cmp("echo", {24'h0, eq.pop_front()}, {24'h0, ed});
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        summarize();
    end

    initial begin
        void'($urandom(32'hF2681ED4));
        do_reset();
        rd(8'h00, 32'h002, 32'h3FF);
        rd(8'h10, 32'h258, 32'hFFF);
        rd(8'h14, 32'h130D, 32'hFFFF);
        rd(8'h0C, 32'h0, 32'h7);
        wb(1'b1, 8'h20, 32'hFFFFFFFF);
        rd(8'h20, 32'h0, 32'hFFFFFFFF);
        lv("ready", 1'b1, rdy);
        lv("dtr", 1'b1, dtr);
        lv("modem_only", 1'b0, mo);
        wb(1'b1, 8'h00, 32'h000);
        rd(8'h04, 32'h0, 32'h4);
        pready <= 1'b1;
        repeat (3) @(posedge clk);
        rd(8'h04, 32'h4, 32'h4);
        $display("test reset and ready straps done");
        for (int k = 0; k < 3; k++) begin
            lat <= 4'($urandom_range(8, 3));
            wb(1'b1, 8'h00, 32'h006);
            txr <= 1'b1;
            repeat (3) @(posedge clk);
            lv("rts", 1'b1, rts);
            lv("tx_hold", 1'b0, txen);
            repeat (14) @(posedge clk);
            lv("tx_go", 1'b1, txen);
            txr <= 1'b0;
            repeat (3) @(posedge clk);
        end
        wb(1'b1, 8'h00, 32'h022);
        txr <= 1'b1;
        repeat (4) @(posedge clk);
        lv("rts_int", 1'b0, rts);
        lv("tx_free", 1'b1, txen);
        rd(8'h04, 32'hC, 32'hC);
        txr  <= 1'b0;
        rrdy <= 1'b1;
        $display("test clear to send done");
        wb(1'b1, 8'h00, 32'h202);
        repeat (3) rx(8'($urandom), 1'b0, 1'b1, 1'b0);
        wb(1'b1, 8'h00, 32'h342);
        repeat (3) rx(8'($urandom), 1'b0, 1'b1, 1'b1);
        lv("echo_reader", 1'b0, run);
        wb(1'b1, 8'h00, 32'h262);
        rx(8'($urandom), 1'b0, 1'b1, 1'b1);
        wb(1'b1, 8'h00, 32'h302);
        repeat (2) @(posedge clk);
        lv("reader_run", 1'b1, run);
        $display("test echo and punch done");
        foreach (dw[i]) begin
            wb(1'b1, 8'h10, dw[i]);
            rd(8'h10, dx[i], 32'hFFF);
        end
        wb(1'b1, 8'h0C, 32'h004);
        wb(1'b1, 8'h00, 32'h192);
        tape(8'h13);
        lv("stop_run", 1'b0, run);
        rd(8'h04, 32'h20, 32'h20);
        lv("irq_stop", 1'b1, irq);
        wb(1'b1, 8'h08, 32'h004);
        repeat (2) @(posedge clk);
        lv("irq_clear", 1'b0, irq);
        wb(1'b1, 8'h00, 32'h092);
        wb(1'b1, 8'h00, 32'h112);
        tape(8'h13);
        lv("local_stop", 1'b1, run);
        tape(8'h0D);
        lv("no_pause", 1'b1, run);
        wb(1'b1, 8'h00, 32'h182);
        tape(8'h13);
        lv("stop_off", 1'b1, run);
        tape(8'h0D);
        lv("pause_run", 1'b0, run);
        rd(8'h04, 32'h10, 32'h10);
        repeat (40) begin
            repeat (50) @(posedge clk);
            lv("pause_hold", 1'b0, run);
        end
        $display("test delay and stop characters done");
        do_reset();
        wb(1'b1, 8'h00, 32'h202);
        rx(8'h55, 1'b1, 1'b1, 1'b0);
        lv("ready_kept", 1'b1, rdy);
        wb(1'b1, 8'h00, 32'h20A);
        rx(8'hAA, 1'b1, 1'b1, 1'b0);
        rx(8'h3C, 1'b0, 1'b1, 1'b0);
        lv("ready_drop", 1'b0, rdy);
        lv("dtr_drop", 1'b0, dtr);
        wb(1'b1, 8'h00, 32'h202);
        repeat (4) @(posedge clk);
        lv("ready_latched", 1'b0, rdy);
        rd(8'h04, 32'h40, 32'h43);
        rd(8'h08, 32'h1, 32'h1);
        lv("irq_masked", 1'b0, irq);
        wb(1'b1, 8'h0C, 32'h001);
        repeat (2) @(posedge clk);
        lv("irq_parity", 1'b1, irq);
        wb(1'b1, 8'h08, 32'h001);
        repeat (2) @(posedge clk);
        lv("irq_w1c", 1'b0, irq);
        rd(8'h08, 32'h0, 32'h1);
        $display("test parity drop and interrupt done");
        summarize();
    end
endmodule : serial_tape_link_options_test
`default_nettype wire
